// ==== include/lcr_pkg.sv ====
// constants, types and the rule overview for the lcd command register block
// Overview of operation
// - increment control holds timing, row step, column step; zero at reset; read at A.
// - timing 0 steps on writes and reads; timing 1 steps on writes only.
// - row:column bits pick none, column only, row only, or both together.
// - with both step bits clear, X and Y never change on RAM access.
// - column-only mode increments X, or decrements it when mirrored, with wrap.
// - row-only mode increments Y with wrap, whatever the mirror setting.
// - cooperative mode steps X each access; an access at RAM column 0FH also increments Y.
// - power control one holds bias, power-save, graphic supply, initialise; read at B.
// - initialise resets internal circuits in master mode only; reads back as zero.
// - graphic supply bit turns booster and converter on or off.
// - power-save stops oscillator, supplies, drive, external clock; keeps RAM and mode.
// - bias bit picks 1/9 or 1/7 graphic bias; segment bias fixed at 1/3.
// - four-bit drive voltage code, sixteen steps, all ones after reset.
// - power control three holds icon, icon clock source, segment supply; read at E.
// - extended bank code E holds duty ratio and boost ratio; zero at reset.
// - boost code 00 four times, 01 three, 10 two, 11 prohibited.
// - bank select writable from either bank, bit 0, read at F.
// - read pointer resets to C; host sets it before reading a register.
// - register read returns selected register on D3 to D0.
// - X spans 00H to 0FH, Y spans 00H to 3FH.
// - column mirror maps host X to RAM columns in normal or reversed order.
// - command/data select low goes to RAM, high to command registers.
`default_nettype none
package lcr_pkg;
  // command codes in D7..D4
  localparam logic [3:0] CMD_INC_CTRL = 4'ha;
  localparam logic [3:0] CMD_PWR_ONE = 4'hb;
  localparam logic [3:0] CMD_READ_PTR = 4'hc;
  localparam logic [3:0] CMD_DRIVE_VOLT = 4'hd;
  localparam logic [3:0] CMD_PWR_THREE = 4'he;
  localparam logic [3:0] CMD_BANK_SEL = 4'hf;
  // read addresses
  localparam logic [3:0] RADDR_INC_CTRL = 4'ha;
  localparam logic [3:0] RADDR_PWR_ONE = 4'hb;
  localparam logic [3:0] RADDR_DRIVE_VOLT = 4'hd;
  localparam logic [3:0] RADDR_PWR_THREE = 4'he;
  localparam logic [3:0] RADDR_BANK_SEL = 4'hf;
  // reset values
  localparam logic [3:0] RST_INC_CTRL = 4'h0;
  localparam logic [3:0] RST_PWR_ONE = 4'h0;
  localparam logic [3:0] RST_DRIVE_VOLT = 4'hf;
  localparam logic [3:0] RST_PWR_THREE = 4'h0;
  localparam logic [3:0] RST_DUTY_BOOST = 4'h0;
  localparam logic [3:0] RST_BANK_SEL = 4'h0;
  localparam logic [3:0] RST_READ_PTR = 4'hc;
  // field positions
  localparam int INC_COL_BIT = 0;
  localparam int INC_ROW_BIT = 1;
  localparam int INC_TIMING_BIT = 2;
  localparam int PWR1_INIT_BIT = 0;
  localparam int PWR1_SUPPLY_BIT = 1;
  localparam int PWR1_SAVE_BIT = 2;
  localparam int PWR1_BIAS_BIT = 3;
  localparam int PWR3_ICON_BIT = 0;
  localparam int PWR3_EXTCLK_BIT = 1;
  localparam int PWR3_SEGSUP_BIT = 3;
  localparam int BANK_BIT = 0;
  // writable masks: undefined bits store as zero
  localparam logic [3:0] MASK_INC_CTRL = 4'h7;
  localparam logic [3:0] MASK_PWR_ONE = 4'he;
  localparam logic [3:0] MASK_PWR_THREE = 4'hb;
  localparam logic [3:0] MASK_BANK_SEL = 4'h1;
  // address limits
  localparam logic [3:0] X_MIN = 4'h0;
  localparam logic [3:0] X_MAX = 4'hf;
  localparam logic [5:0] Y_MIN = 6'h00;
  localparam logic [5:0] Y_MAX = 6'h3f;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;

  typedef enum logic [3:0] {
    STEP_NONE = 4'b0001,
    STEP_COL = 4'b0010,
    STEP_ROW = 4'b0100,
    STEP_BOTH = 4'b1000
  } lcr_step_e;

  typedef struct packed {
    logic commandDataSelect;
    logic write;
    logic read;
    logic [7:0] data;
  } lcr_host_req_s;

  typedef struct packed {
    logic xLoad;
    logic [3:0] xValue;
    logic yLoad;
    logic [5:0] yValue;
  } lcr_addr_load_s;
endpackage : lcr_pkg
`default_nettype wire

// ==== verilog/lcr_command_regs.sv ====
// command register file, ram address stepping and power controls
`timescale 1ns/1ps
`default_nettype none
module lcr_command_regs (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire lcr_pkg::lcr_host_req_s hostReq,
  input wire lcr_pkg::lcr_addr_load_s addrLoad,
  input wire logic columnMirror,
  input wire logic masterMode,
  input wire logic [7:0] ramReadData,
  output logic [7:0] hostReadData,
  output logic ramWriteStrobe,
  output logic ramReadStrobe,
  output logic [3:0] ramColumn,
  output logic [5:0] ramRow,
  output logic [7:0] ramWriteData,
  output logic [3:0] columnAddr,
  output logic [5:0] rowAddr,
  output logic internalInitPulse,
  output logic oscillatorRun,
  output logic driverOutputsGround,
  output logic externalClockAccept,
  output logic graphicSupplyOn,
  output logic graphicBiasSeventh,
  output logic segmentSupplyOn,
  output logic iconEnable,
  output logic iconClockExternal,
  output logic [3:0] driveVoltageCode,
  output logic [1:0] dutyRatioSelect,
  output logic [1:0] boostRatioSelect,
  output logic extendedBankSelect
);

  // step mode from the two step bits
  function automatic lcr_pkg::lcr_step_e stepDecode(input logic row, input logic col);
    lcr_pkg::lcr_step_e mode;
    mode = lcr_pkg::STEP_NONE;
    case ({row, col})
      2'b01: mode = lcr_pkg::STEP_COL;
      2'b10: mode = lcr_pkg::STEP_ROW;
      2'b11: mode = lcr_pkg::STEP_BOTH;
      default: mode = lcr_pkg::STEP_NONE;
    endcase
    return mode;
  endfunction : stepDecode

  // host X to ram column, reversed when mirrored
  function automatic logic [3:0] mapColumn(input logic mirror, input logic [3:0] x);
    return mirror ? (lcr_pkg::X_MAX - x) : x;
  endfunction : mapColumn

  // write strobe for one command code within the bank that owns it
  function automatic logic codeWrite(input logic strobe, input logic bankOk,
    input logic [3:0] code, input logic [3:0] want);
    return strobe & bankOk & (code == want);
  endfunction : codeWrite

  logic [3:0] incCtrl_r;
  logic [3:0] pwrOne_r;
  logic [3:0] driveVolt_r;
  logic [3:0] pwrThree_r;
  logic [3:0] dutyBoost_r;
  logic [3:0] bankSel_r;
  logic [3:0] readPtr_r;
  logic [3:0] xAddr_r;
  logic [5:0] yAddr_r;
  logic [3:0] xAddr_nxt;
  logic [5:0] yAddr_nxt;
  logic [7:0] hostReadData_r;
  logic ramWrite_r;
  logic ramRead_r;
  logic [3:0] ramColumn_r;
  logic [5:0] ramRow_r;
  logic [7:0] ramWriteData_r;
  logic initPulse_r;

  // bus decode
  wire logic [3:0] cmdCode;
  wire logic [3:0] cmdArg;
  wire logic regWrite;
  wire logic regRead;
  wire logic ramWrite;
  wire logic ramRead;
  wire logic bankZero;
  wire logic wrIncCtrl;
  wire logic wrPwrOne;
  wire logic wrReadPtr;
  wire logic wrDriveVolt;
  wire logic wrPwrThree;
  wire logic wrDutyBoost;
  wire logic wrBankSel;
  wire logic initRequest;

  assign cmdCode = hostReq.data[7:4];
  assign cmdArg = hostReq.data[3:0];
  assign regWrite = hostReq.write & hostReq.commandDataSelect;
  assign regRead = hostReq.read & hostReq.commandDataSelect;
  assign ramWrite = hostReq.write & ~hostReq.commandDataSelect;
  assign ramRead = hostReq.read & ~hostReq.commandDataSelect;

  // codes A to D only answer in the base bank; in the extended bank code E writes the duty and boost register
  assign bankZero = ~bankSel_r[lcr_pkg::BANK_BIT];
  assign wrIncCtrl = codeWrite(regWrite, bankZero, cmdCode, lcr_pkg::CMD_INC_CTRL);
  assign wrPwrOne = codeWrite(regWrite, bankZero, cmdCode, lcr_pkg::CMD_PWR_ONE);
  assign wrReadPtr = codeWrite(regWrite, bankZero, cmdCode, lcr_pkg::CMD_READ_PTR);
  assign wrDriveVolt = codeWrite(regWrite, bankZero, cmdCode, lcr_pkg::CMD_DRIVE_VOLT);
  assign wrPwrThree = codeWrite(regWrite, bankZero, cmdCode, lcr_pkg::CMD_PWR_THREE);
  assign wrDutyBoost = codeWrite(regWrite, ~bankZero, cmdCode, lcr_pkg::CMD_PWR_THREE);
  assign wrBankSel = regWrite & (cmdCode == lcr_pkg::CMD_BANK_SEL);
  assign initRequest = wrPwrOne & cmdArg[lcr_pkg::PWR1_INIT_BIT] & masterMode;

  // stepping decode
  wire lcr_pkg::lcr_step_e stepMode;
  wire logic stepQualify;
  wire logic [3:0] xStepped;
  wire logic [5:0] yStepped;
  wire logic atLastColumn;

  assign stepMode = stepDecode(incCtrl_r[lcr_pkg::INC_ROW_BIT], incCtrl_r[lcr_pkg::INC_COL_BIT]);
  // read stepping gated by timing bit
  assign stepQualify = ramWrite | (ramRead & ~incCtrl_r[lcr_pkg::INC_TIMING_BIT]);
  assign xStepped = columnMirror ? (xAddr_r - 4'h1) : (xAddr_r + 4'h1);
  // six bits span 00H to 3FH
  assign yStepped = (yAddr_r == lcr_pkg::Y_MAX) ? lcr_pkg::Y_MIN : (yAddr_r + 6'h01);
  assign atLastColumn = mapColumn(columnMirror, xAddr_r) == lcr_pkg::X_MAX;

  always_comb begin
    xAddr_nxt = xAddr_r;
    yAddr_nxt = yAddr_r;
    if (addrLoad.xLoad) begin
      xAddr_nxt = addrLoad.xValue;
    end
    if (addrLoad.yLoad) begin
      yAddr_nxt = addrLoad.yValue;
    end
    // a step in the load cycle wins and starts from the old address
    if (stepQualify) begin
      case (stepMode)
        lcr_pkg::STEP_COL: begin
          xAddr_nxt = xStepped;
        end
        lcr_pkg::STEP_ROW: begin
          yAddr_nxt = yStepped;
        end
        lcr_pkg::STEP_BOTH: begin
          xAddr_nxt = xStepped;
          yAddr_nxt = atLastColumn ? yStepped : yAddr_r;
        end
        default: begin
          xAddr_nxt = xAddr_r;
          yAddr_nxt = yAddr_r;
        end
      endcase
    end
  end

  // read back mux
  wire logic [3:0] readSel;
  wire logic [3:0] pwrThreeView;

  // code E shows the register of the current bank
  assign pwrThreeView = bankZero ? pwrThree_r : dutyBoost_r;
  assign readSel =
    (readPtr_r == lcr_pkg::RADDR_INC_CTRL) ? incCtrl_r :
    (readPtr_r == lcr_pkg::RADDR_PWR_ONE) ? pwrOne_r :
    (readPtr_r == lcr_pkg::RADDR_DRIVE_VOLT) ? driveVolt_r :
    (readPtr_r == lcr_pkg::RADDR_PWR_THREE) ? pwrThreeView :
    (readPtr_r == lcr_pkg::RADDR_BANK_SEL) ? bankSel_r : lcr_pkg::NIBBLE_ZERO;

  // control registers; initialise returns them to defaults too
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      incCtrl_r <= lcr_pkg::RST_INC_CTRL;
      pwrOne_r <= lcr_pkg::RST_PWR_ONE;
      driveVolt_r <= lcr_pkg::RST_DRIVE_VOLT;
      pwrThree_r <= lcr_pkg::RST_PWR_THREE;
      dutyBoost_r <= lcr_pkg::RST_DUTY_BOOST;
      bankSel_r <= lcr_pkg::RST_BANK_SEL;
      readPtr_r <= lcr_pkg::RST_READ_PTR;
    end else if (clkEn) begin
      if (initRequest) begin
        incCtrl_r <= lcr_pkg::RST_INC_CTRL;
        pwrOne_r <= lcr_pkg::RST_PWR_ONE;
        driveVolt_r <= lcr_pkg::RST_DRIVE_VOLT;
        pwrThree_r <= lcr_pkg::RST_PWR_THREE;
        dutyBoost_r <= lcr_pkg::RST_DUTY_BOOST;
        bankSel_r <= lcr_pkg::RST_BANK_SEL;
        readPtr_r <= lcr_pkg::RST_READ_PTR;
      end else begin
        if (wrIncCtrl) begin
          incCtrl_r <= cmdArg & lcr_pkg::MASK_INC_CTRL;
        end
        if (wrPwrOne) begin
          pwrOne_r <= cmdArg & lcr_pkg::MASK_PWR_ONE;
        end
        if (wrDriveVolt) begin
          driveVolt_r <= cmdArg;
        end
        if (wrPwrThree) begin
          pwrThree_r <= cmdArg & lcr_pkg::MASK_PWR_THREE;
        end
        if (wrDutyBoost) begin
          dutyBoost_r <= cmdArg;
        end
        if (wrBankSel) begin
          bankSel_r <= cmdArg & lcr_pkg::MASK_BANK_SEL;
        end
        if (wrReadPtr) begin
          readPtr_r <= cmdArg;
        end
      end
    end
  end

  // addresses, ram strobes and read data
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xAddr_r <= lcr_pkg::X_MIN;
      yAddr_r <= lcr_pkg::Y_MIN;
      hostReadData_r <= 8'h00;
      ramWrite_r <= 1'b0;
      ramRead_r <= 1'b0;
      ramColumn_r <= lcr_pkg::X_MIN;
      ramRow_r <= lcr_pkg::Y_MIN;
      ramWriteData_r <= 8'h00;
      initPulse_r <= 1'b0;
    end else if (clkEn) begin
      xAddr_r <= xAddr_nxt;
      yAddr_r <= yAddr_nxt;
      ramWrite_r <= ramWrite;
      ramRead_r <= ramRead;
      ramColumn_r <= mapColumn(columnMirror, xAddr_r);
      ramRow_r <= yAddr_r;
      if (ramWrite) begin
        ramWriteData_r <= hostReq.data;
      end
      initPulse_r <= initRequest;
      if (regRead) begin
        hostReadData_r <= {lcr_pkg::NIBBLE_ZERO, readSel};
      end else if (ramRead) begin
        hostReadData_r <= ramReadData;
      end
    end
  end

  // power-save only gates outputs here; the stored mode survives it
  wire logic powerSave;
  assign powerSave = pwrOne_r[lcr_pkg::PWR1_SAVE_BIT];

  assign hostReadData = hostReadData_r;
  assign ramWriteStrobe = ramWrite_r;
  assign ramReadStrobe = ramRead_r;
  assign ramColumn = ramColumn_r;
  assign ramRow = ramRow_r;
  assign ramWriteData = ramWriteData_r;
  assign columnAddr = xAddr_r;
  assign rowAddr = yAddr_r;
  assign internalInitPulse = initPulse_r;
  // power-save stops clocks, supplies and drive; registers untouched
  assign oscillatorRun = ~powerSave;
  assign driverOutputsGround = powerSave;
  assign externalClockAccept = ~powerSave;
  assign graphicSupplyOn = pwrOne_r[lcr_pkg::PWR1_SUPPLY_BIT] & ~powerSave;
  // high means 1/7, segment bias is fixed outside this block
  assign graphicBiasSeventh = pwrOne_r[lcr_pkg::PWR1_BIAS_BIT];
  assign segmentSupplyOn = pwrThree_r[lcr_pkg::PWR3_SEGSUP_BIT] & ~powerSave;
  assign iconEnable = pwrThree_r[lcr_pkg::PWR3_ICON_BIT];
  assign iconClockExternal = pwrThree_r[lcr_pkg::PWR3_EXTCLK_BIT];
  assign driveVoltageCode = driveVolt_r;
  assign dutyRatioSelect = dutyBoost_r[3:2];
  // code passed as written, 11 is the host's to avoid
  assign boostRatioSelect = dutyBoost_r[1:0];
  assign extendedBankSelect = bankSel_r[lcr_pkg::BANK_BIT];

endmodule : lcr_command_regs
`default_nettype wire

// ==== verif/lcr_command_regs_monitor.sv ====
// port assertions for the command register block
`timescale 1ns/1ps
`default_nettype none
module lcr_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clkEn,
  input wire lcr_pkg::lcr_host_req_s hostReq,
  input wire lcr_pkg::lcr_addr_load_s addrLoad,
  input wire logic columnMirror,
  input wire logic masterMode,
  input wire logic [7:0] hostReadData,
  input wire logic ramWriteStrobe,
  input wire logic [3:0] ramColumn,
  input wire logic [5:0] ramRow,
  input wire logic [3:0] columnAddr,
  input wire logic [5:0] rowAddr,
  input wire logic internalInitPulse,
  input wire logic oscillatorRun,
  input wire logic driverOutputsGround,
  input wire logic externalClockAccept,
  input wire logic graphicSupplyOn,
  input wire logic segmentSupplyOn,
  input wire logic [3:0] driveVoltageCode
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  ram_write_a: assert property (clkEn && hostReq.write && !hostReq.commandDataSelect
    |=> ramWriteStrobe) else $error("ram write gave no strobe");
  cmd_write_a: assert property (clkEn && hostReq.write && hostReq.commandDataSelect
    |=> !ramWriteStrobe) else $error("command write reached ram");
  save_outputs_a: assert property (oscillatorRun == externalClockAccept
    && oscillatorRun != driverOutputsGround) else $error("power-save outputs disagree");
  supply_save_a: assert property (graphicSupplyOn || segmentSupplyOn |-> oscillatorRun)
    else $error("supply on during power-save");
  col_step_a: assert property (ramWriteStrobe && !$past(columnMirror) && !$past(addrLoad.xLoad)
    && columnAddr != ramColumn |-> columnAddr == ramColumn + 4'h1) else $error("bad column step");
  row_step_a: assert property (ramWriteStrobe && !$past(addrLoad.yLoad) && rowAddr != ramRow
    |-> rowAddr == ramRow + 6'h01) else $error("bad row step");
  init_master_a: assert property (internalInitPulse |-> $past(masterMode) && $past(hostReq.write))
    else $error("initialise without master write");
  init_reset_a: assert property (internalInitPulse |=> !internalInitPulse
    && driveVoltageCode == 4'hf) else $error("initialise left drive code");
  read_upper_a: assert property (clkEn && hostReq.read && hostReq.commandDataSelect
    |=> hostReadData[7:4] == 4'h0) else $error("register read upper bits set");
  read_hold_a: assert property (!$past(hostReq.read) && $past(rstn) |-> $stable(hostReadData))
    else $error("read data moved without read");
endmodule : lcr_monitor
bind lcr_command_regs lcr_monitor u_mon (.core_clk, .rstn, .clkEn, .hostReq, .addrLoad,
  .columnMirror, .masterMode, .hostReadData, .ramWriteStrobe, .ramColumn, .ramRow, .columnAddr,
  .rowAddr, .internalInitPulse, .oscillatorRun, .driverOutputsGround, .externalClockAccept,
  .graphicSupplyOn, .segmentSupplyOn, .driveVoltageCode);
`default_nettype wire

// ==== verif/lcr_host_model.sv ====
// host processor model: bus cycles and address loads
`timescale 1ns/1ps
`default_nettype none
module lcr_host_model (
  input wire logic core_clk,
  input wire logic [7:0] hostReadData,
  output var lcr_pkg::lcr_host_req_s hostReq,
  output var lcr_pkg::lcr_addr_load_s addrLoad
);
  initial begin
    hostReq = '0;
    addrLoad = '0;
  end
  // select steers the access
  // released bus shows inverted data so stale values never match
  task automatic cycle(input logic cs, input logic wr, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    hostReq = '{cs, wr, !wr, d};
    @(posedge core_clk);
    #1;
    hostReq = '{cs, 1'h0, 1'h0, ~d};
  endtask : cycle
  task automatic wr(input logic cs, input logic [7:0] d);
    cycle(cs, 1'h1, d);
  endtask : wr
  task automatic rd(input logic cs, output logic [7:0] q);
    cycle(cs, 1'h0, 8'h00);
    q = hostReadData;
  endtask : rd
  task automatic setxy(input logic [3:0] x, input logic [5:0] y);
    @(posedge core_clk);
    #1;
    addrLoad = '{1'h1, x, 1'h1, y};
    @(posedge core_clk);
    #1;
    addrLoad = '{1'h0, ~x, 1'h0, ~y};
  endtask : setxy
endmodule : lcr_host_model
`default_nettype wire

// ==== verif/test_lcr_command_regs.sv ====
// self-checking bench for the command register block
`timescale 1ns/1ps
`default_nettype none
module test_lcr_command_regs;
  logic core_clk;
  logic rstn;
  logic clkEn;
  logic columnMirror;
  logic masterMode;
  logic [7:0] ramReadData;
  lcr_pkg::lcr_host_req_s hostReq;
  lcr_pkg::lcr_addr_load_s addrLoad;
  logic [7:0] hostReadData;
  logic ramWr;
  logic ramRd;
  logic [3:0] ramCol;
  logic [5:0] ramRw;
  logic [7:0] ramWd;
  logic [3:0] columnAddr;
  logic [5:0] rowAddr;
  logic initPulse;
  logic oscRun;
  logic drvGround;
  logic extAccept;
  logic gSupply;
  logic bias7;
  logic segSupply;
  logic icon;
  logic iconExt;
  logic [3:0] driveCode;
  logic [1:0] duty;
  logic [1:0] boost;
  logic bank;
  int err_count = 0;
  int cmp_count = 0;
  lcr_command_regs u_dut (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn), .hostReq(hostReq),
    .addrLoad(addrLoad), .columnMirror(columnMirror), .masterMode(masterMode),
    .ramReadData(ramReadData), .hostReadData(hostReadData), .ramWriteStrobe(ramWr),
    .ramReadStrobe(ramRd), .ramColumn(ramCol), .ramRow(ramRw), .ramWriteData(ramWd),
    .columnAddr(columnAddr), .rowAddr(rowAddr),
    .internalInitPulse(initPulse), .oscillatorRun(oscRun), .driverOutputsGround(drvGround),
    .externalClockAccept(extAccept), .graphicSupplyOn(gSupply), .graphicBiasSeventh(bias7),
    .segmentSupplyOn(segSupply), .iconEnable(icon), .iconClockExternal(iconExt),
    .driveVoltageCode(driveCode), .dutyRatioSelect(duty), .boostRatioSelect(boost),
    .extendedBankSelect(bank));
  lcr_host_model u_host (.core_clk(core_clk), .hostReadData(hostReadData), .hostReq(hostReq),
    .addrLoad(addrLoad));
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rdreg(input logic [3:0] ptr, input logic [7:0] exp);
    logic [7:0] q;
    u_host.wr(1'h1, {lcr_pkg::CMD_READ_PTR, ptr});
    u_host.rd(1'h1, q);
    chk("register read", q, exp);
  endtask : rdreg
  task automatic t_reset;
    logic [7:0] q;
    // every register away from its default, pointer left alone
    u_host.wr(1'h1, 8'ha7);
    u_host.wr(1'h1, 8'hb2);
    u_host.wr(1'h1, 8'hd3);
    u_host.wr(1'h1, 8'he9);
    u_host.wr(1'h1, 8'hf1);
    u_host.wr(1'h1, 8'he5);
    u_host.rd(1'h1, q);
    chk("pointer default", q, 8'h00);
    // mid-run reset must restore all of them
    @(posedge core_clk);
    #1;
    rstn = 1'h0;
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'h1;
    chk("duty boost reset", {4'h0, duty, boost}, 8'h00);
    rdreg(lcr_pkg::RADDR_INC_CTRL, 8'h00);
    rdreg(lcr_pkg::RADDR_PWR_ONE, 8'h00);
    rdreg(lcr_pkg::RADDR_DRIVE_VOLT, 8'h0f);
    rdreg(lcr_pkg::RADDR_PWR_THREE, 8'h00);
    rdreg(lcr_pkg::RADDR_BANK_SEL, 8'h00);
  endtask : t_reset
  task automatic t_power;
    u_host.wr(1'h1, 8'hba);
    chk("supply bias", {6'h0, gSupply, bias7}, 8'h03);
    rdreg(lcr_pkg::RADDR_PWR_ONE, 8'h0a);
    // a frozen cycle must drop the write
    clkEn = 1'h0;
    u_host.wr(1'h1, 8'hd5);
    clkEn = 1'h1;
    chk("frozen drive", 8'(driveCode), 8'h0f);
    u_host.wr(1'h1, 8'hbe);
    chk("save outputs", {4'h0, oscRun, drvGround, extAccept, gSupply}, 8'h04);
    masterMode = 1'h0;
    u_host.wr(1'h1, 8'hb3);
    chk("slave init", 8'(initPulse), 8'h00);
    rdreg(lcr_pkg::RADDR_PWR_ONE, 8'h02);
    masterMode = 1'h1;
    u_host.wr(1'h1, 8'hd8);
    chk("drive code", 8'(driveCode), 8'h08);
    u_host.wr(1'h1, 8'hb1);
    chk("master init", 8'(initPulse), 8'h01);
    repeat (4) @(posedge core_clk);
    rdreg(lcr_pkg::RADDR_PWR_ONE, 8'h00);
    chk("drive after init", 8'(driveCode), 8'h0f);
  endtask : t_power
  task automatic ram_case(input logic [3:0] mode, input logic mir, input logic isRd,
    input logic [3:0] x, input logic [5:0] y, input logic [3:0] ex, input logic [5:0] ey);
    columnMirror = mir;
    ramReadData = {x, 4'h9};
    u_host.wr(1'h1, {lcr_pkg::CMD_INC_CTRL, mode});
    u_host.setxy(x, y);
    u_host.cycle(1'h0, !isRd, 8'h3c);
    chk("ramWriteStrobe", 8'(ramWr), 8'(!isRd));
    chk("ramReadStrobe", 8'(ramRd), 8'(isRd));
    chk("ramColumn", 8'(ramCol), 8'(mir ? 4'hf - x : x));
    chk("ramRow", 8'(ramRw), 8'(y));
    chk("ram data", isRd ? hostReadData : ramWd, isRd ? {x, 4'h9} : 8'h3c);
    chk("columnAddr", 8'(columnAddr), 8'(ex));
    chk("rowAddr", 8'(rowAddr), 8'(ey));
  endtask : ram_case
  task automatic t_step;
    ram_case(4'h0, 1'h0, 1'h0, 4'h5, 6'h05, 4'h5, 6'h05);
    ram_case(4'h4, 1'h0, 1'h1, 4'h5, 6'h05, 4'h5, 6'h05);
    ram_case(4'h1, 1'h0, 1'h0, 4'hf, 6'h09, 4'h0, 6'h09);
    ram_case(4'h1, 1'h1, 1'h0, 4'h0, 6'h09, 4'hf, 6'h09);
    ram_case(4'h2, 1'h1, 1'h0, 4'h7, 6'h3f, 4'h7, 6'h00);
    ram_case(4'h3, 1'h0, 1'h0, 4'he, 6'h03, 4'hf, 6'h03);
    ram_case(4'h3, 1'h0, 1'h0, 4'hf, 6'h03, 4'h0, 6'h04);
    ram_case(4'h3, 1'h1, 1'h0, 4'h0, 6'h03, 4'hf, 6'h04);
    ram_case(4'h1, 1'h0, 1'h1, 4'h2, 6'h00, 4'h3, 6'h00);
    ram_case(4'h5, 1'h0, 1'h1, 4'h2, 6'h00, 4'h2, 6'h00);
    ram_case(4'h5, 1'h0, 1'h0, 4'h2, 6'h00, 4'h3, 6'h00);
    rdreg(lcr_pkg::RADDR_INC_CTRL, 8'h05);
  endtask : t_step
  task automatic t_bank;
    logic [7:0] q;
    u_host.wr(1'h1, 8'heb);
    chk("icon segment", {5'h0, icon, iconExt, segSupply}, 8'h07);
    // pointer loads are base-bank only, so aim at E before switching
    u_host.wr(1'h1, {lcr_pkg::CMD_READ_PTR, lcr_pkg::RADDR_PWR_THREE});
    u_host.wr(1'h1, 8'hf1);
    chk("bank set", 8'(bank), 8'h01);
    // boost codes 10 and 11 stay unused by the host
    for (int i = 0; i < 4; i++) begin
      u_host.wr(1'h1, {4'he, 2'(i), 1'h0, 1'(i)});
      chk("duty", 8'(duty), 8'(i));
      chk("boost", 8'(boost), 8'(i % 2));
    end
    u_host.rd(1'h1, q);
    chk("extended read", q, 8'h0d);
    // code A in the extended bank must be dropped
    u_host.wr(1'h1, 8'ha7);
    u_host.wr(1'h1, 8'hf0);
    chk("bank clear", 8'(bank), 8'h00);
    rdreg(lcr_pkg::RADDR_PWR_THREE, 8'h0b);
    rdreg(lcr_pkg::RADDR_INC_CTRL, 8'h05);
  endtask : t_bank
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    rstn = 1'h0;
    clkEn = 1'h1;
    columnMirror = 1'h0;
    masterMode = 1'h1;
    ramReadData = 8'h00;
    repeat (10) @(posedge core_clk);
    #1;
    rstn = 1'h1;
    t_reset();
    t_power();
    t_step();
    t_bank();
    end_sim();
  end
  initial begin
    #400000;
    err_count++;
    end_sim();
  end
endmodule : test_lcr_command_regs
`default_nettype wire
